//--- logic/atp_deadtime.v
// dead-time down counter of one phase pair
module atp_deadtime #(
  parameter DW = 12
) (
  input wire i_clock,
  input wire i_nrst,
  input wire i_load,
  input wire [DW-1:0] i_reload,
  output wire o_dead
);
  localparam [DW-1:0] DT_IDLE = {DW{1'b1}};
  localparam [DW-1:0] DT_ONE = {{(DW-1){1'b0}}, 1'b1};
  reg [DW-1:0] deadtime_counter;

  always @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      deadtime_counter <= DT_IDLE;
    end
    else if (i_load)
    begin
      deadtime_counter <= i_reload;
    end
    else if (deadtime_counter != DT_IDLE)
    begin
      deadtime_counter <= deadtime_counter - DT_ONE;
    end
  end

  // reload value plus one cycles away from the idle code
  assign o_dead = (deadtime_counter != DT_IDLE);
endmodule // atp_deadtime

//--- logic/atp_map.vh
// register map, field positions and reset values of the asymmetric pwm unit
`ifndef ATP_MAP_VH
`define ATP_MAP_VH
`define ATP_ADDR_W 5
`define ATP_REG_CTRL 5'h00
`define ATP_REG_PBUF 5'h01
`define ATP_REG_CBUF0 5'h02
`define ATP_REG_DTRR 5'h07
`define ATP_REG_PCMP 5'h08
`define ATP_REG_CNT 5'h09
`define ATP_REG_STAT 5'h0a
`define ATP_REG_CCMP0 5'h0b
`define ATP_REG_EVT 5'h10
`define ATP_NCH 5
`define ATP_NCH_A 5'h05
`define ATP_NPH 3
`define ATP_B_RUN 0
`define ATP_B_DTDIS 1
`define ATP_B_DXFER 2
`define ATP_B_PXFER 3
`define ATP_F_MODE_LO 4
`define ATP_F_MODE_HI 5
`define ATP_B_ALVH 6
`define ATP_F_PRE_LO 8
`define ATP_F_PRE_HI 10
`define ATP_PRE_W 3
`define ATP_CTRL_RST 16'h000c
`define ATP_CTRL_MASK 16'h077f
`define ATP_MODE_ASYM 2'b01
`define ATP_EVT_W 7
`define ATP_EVT_UNDER 0
`define ATP_EVT_TOP 1
`define ATP_EVT_CH0 2
`define ATP_RD_ZERO 16'h0000
`endif

//--- logic/atp_pwm.v
// asymmetric triangular-wave six-output pwm unit with dead time
//
// Added by the designer: the strobed register port and the address map.
`include "atp_map.vh"

module atp_pwm #(
  parameter CW = 16,
  parameter DW = 12
) (
  input wire i_clock,
  input wire i_nrst,
  input wire [`ATP_ADDR_W-1:0] i_addr,
  input wire [CW-1:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [CW-1:0] o_rdata,
  output reg [2*`ATP_NPH-1:0] o_phase_out,
  output reg [2*`ATP_NPH-1:0] o_phase_oe,
  output reg o_underflow_irq,
  output reg o_period_match_irq,
  output reg [`ATP_NPH-1:0] o_duty_match_irq,
  output reg [`ATP_NCH-`ATP_NPH-1:0] o_aux_match_irq
);
  localparam [CW-1:0] CNT_ONE = {{(CW-1){1'b0}}, 1'b1};
  localparam [CW-1:0] CNT_ZERO = {CW{1'b0}};

  // address decode of the five compare channels
  function chan_hit;
    input [`ATP_ADDR_W-1:0] a;
    input [`ATP_ADDR_W-1:0] base;
    begin
      chan_hit = (a >= base) && (a < base + `ATP_NCH_A);
    end
  endfunction

  function [2:0] chan_idx;
    input [`ATP_ADDR_W-1:0] a;
    input [`ATP_ADDR_W-1:0] base;
    reg [`ATP_ADDR_W-1:0] d;
    begin
      d = a - base;
      chan_idx = d[2:0];
    end
  endfunction

  reg [CW-1:0] timer_control_reg;
  reg [CW-1:0] period_buffer;
  reg [CW-1:0] period_compare;
  reg [CW-1:0] updown_counter;
  reg [DW-1:0] deadtime_reload;
  reg [CW-1:0] cbuf [0:`ATP_NCH-1];
  reg count_down;
  reg run_d;
  reg [`ATP_PRE_W-1:0] pre_cnt;
  reg tick;
  reg [`ATP_EVT_W-1:0] evt_flags;
  reg [CW-1:0] next_rdata;
  reg [2*`ATP_NPH-1:0] next_out;
  integer k;

  wire count_run_bit = timer_control_reg[`ATP_B_RUN];
  wire deadtime_disable_bit = timer_control_reg[`ATP_B_DTDIS];
  wire duty_transfer_enable = timer_control_reg[`ATP_B_DXFER];
  wire period_transfer_enable = timer_control_reg[`ATP_B_PXFER];
  wire [1:0] mode_select_field = timer_control_reg[`ATP_F_MODE_HI:`ATP_F_MODE_LO];
  wire active_high = timer_control_reg[`ATP_B_ALVH];
  wire [`ATP_PRE_W-1:0] pre_div = timer_control_reg[`ATP_F_PRE_HI:`ATP_F_PRE_LO];

  wire mode_on = (mode_select_field == `ATP_MODE_ASYM);
  wire run = count_run_bit & mode_on;
  wire run_rise = run & ~run_d;
  wire at_zero = (updown_counter == CNT_ZERO);
  wire at_top = (updown_counter == period_compare);
  wire under_ev = tick & count_down & at_zero;
  wire top_ev = tick & ~count_down & at_top & ~at_zero;
  wire xfer_now = (under_ev | top_ev) & duty_transfer_enable;
  // the bottom point belongs to up-counting, the top point to down-counting
  wire phase_up = at_zero ? 1'b1 : (at_top ? 1'b0 : ~count_down);

  wire [`ATP_NCH*CW-1:0] ccmp_flat;
  wire [`ATP_NCH-1:0] mhit;
  wire [`ATP_NPH-1:0] ff;
  wire [`ATP_NPH-1:0] dead;
  wire [`ATP_NPH-1:0] pos_act;
  wire [`ATP_NPH-1:0] neg_act;

  // count clock divider
  always @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pre_cnt <= {`ATP_PRE_W{1'b0}};
      tick <= 1'b0;
      run_d <= 1'b0;
    end
    else
    begin
      run_d <= run;
      if (!run || run_rise)
      begin
        pre_cnt <= {`ATP_PRE_W{1'b0}};
        tick <= 1'b0;
      end
      else if (pre_cnt == pre_div)
      begin
        pre_cnt <= {`ATP_PRE_W{1'b0}};
        tick <= 1'b1;
      end
      else
      begin
        pre_cnt <= pre_cnt + {{(`ATP_PRE_W-1){1'b0}}, 1'b1};
        tick <= 1'b0;
      end
    end
  end

  // up/down counter and period transfer
  always @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      updown_counter <= CNT_ZERO;
      count_down <= 1'b0;
      period_compare <= CNT_ZERO;
    end
    else if (run_rise)
    begin
      updown_counter <= CNT_ZERO;
      count_down <= 1'b0;
      period_compare <= period_buffer;
    end
    else if (tick)
    begin
      if (under_ev)
      begin
        count_down <= 1'b0;
        updown_counter <= updown_counter + CNT_ONE;
        if (period_transfer_enable)
        begin
          period_compare <= period_buffer;
        end
      end
      else if (top_ev)
      begin
        count_down <= 1'b1;
        updown_counter <= updown_counter - CNT_ONE;
      end
      else if (count_down)
      begin
        updown_counter <= updown_counter - CNT_ONE;
      end
      else
      begin
        updown_counter <= updown_counter + CNT_ONE;
      end
    end
  end

  // compare channels: three duty, two auxiliary
  genvar g;
  generate
    for (g = 0; g < `ATP_NCH; g = g + 1)
    begin : gen_ch
      reg [CW-1:0] cmp_q;
      wire [CW-1:0] eff = xfer_now ? cbuf[g] : cmp_q;
      // a value above the period is never reached
      wire hit = tick & (updown_counter == eff);
      assign ccmp_flat[g*CW +: CW] = cmp_q;
      assign mhit[g] = hit;

      always @(posedge i_clock or negedge i_nrst)
      begin
        if (!i_nrst)
        begin
          cmp_q <= CNT_ZERO;
        end
        else if (!run)
        begin
          cmp_q <= cbuf[g];
        end
        else if (xfer_now)
        begin
          cmp_q <= cbuf[g];
        end
      end

      if (g < `ATP_NPH)
      begin : gen_phase
        reg ff_q;
        wire chg = hit & (ff_q != phase_up);
        always @(posedge i_clock or negedge i_nrst)
        begin
          if (!i_nrst)
          begin
            ff_q <= 1'b0;
          end
          else if (run_rise)
          begin
            ff_q <= 1'b0;
          end
          else if (hit)
          begin
            ff_q <= phase_up;
          end
        end

        atp_deadtime #(
          .DW(DW)
        ) u_dt (
          .i_clock(i_clock),
          .i_nrst(i_nrst),
          .i_load(chg),
          .i_reload(deadtime_reload),
          .o_dead(dead[g])
        );

        assign ff[g] = ff_q;
        // a retrigger inside dead time keeps both sides inactive
        assign pos_act[g] = run & ff_q & (deadtime_disable_bit | ~dead[g]);
        assign neg_act[g] = ~run | (~ff_q & (deadtime_disable_bit | ~dead[g]));
      end
    end
  endgenerate

  // pin levels
  always @*
  begin
    next_out = {2*`ATP_NPH{1'b0}};
    for (k = 0; k < `ATP_NPH; k = k + 1)
    begin
      next_out[2*k] = active_high ? pos_act[k] : ~pos_act[k];
      next_out[2*k+1] = active_high ? neg_act[k] : ~neg_act[k];
    end
  end

  always @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_phase_out <= {2*`ATP_NPH{1'b0}};
      o_phase_oe <= {2*`ATP_NPH{1'b0}};
      o_underflow_irq <= 1'b0;
      o_period_match_irq <= 1'b0;
      o_duty_match_irq <= {`ATP_NPH{1'b0}};
      o_aux_match_irq <= {(`ATP_NCH-`ATP_NPH){1'b0}};
    end
    else
    begin
      o_phase_oe <= {2*`ATP_NPH{mode_on}};
      o_phase_out <= mode_on ? next_out : {2*`ATP_NPH{1'b0}};
      o_underflow_irq <= under_ev;
      o_period_match_irq <= top_ev;
      o_duty_match_irq <= mhit[`ATP_NPH-1:0];
      o_aux_match_irq <= mhit[`ATP_NCH-1:`ATP_NPH];
    end
  end

  // register writes
  always @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      timer_control_reg <= `ATP_CTRL_RST;
      period_buffer <= CNT_ZERO;
      deadtime_reload <= {DW{1'b0}};
    end
    else if (i_wr)
    begin
      case (i_addr)
        `ATP_REG_CTRL:
        begin
          timer_control_reg <= i_wdata & `ATP_CTRL_MASK;
        end
        `ATP_REG_PBUF:
        begin
          period_buffer <= i_wdata;
        end
        `ATP_REG_DTRR:
        begin
          deadtime_reload <= i_wdata[DW-1:0];
        end
        default:
        begin
          timer_control_reg <= timer_control_reg;
        end
      endcase
    end
  end

  generate
    for (g = 0; g < `ATP_NCH; g = g + 1)
    begin : gen_buf
      always @(posedge i_clock or negedge i_nrst)
      begin
        if (!i_nrst)
        begin
          cbuf[g] <= CNT_ZERO;
        end
        else if (i_wr && chan_hit(i_addr, `ATP_REG_CBUF0) &&
                 (chan_idx(i_addr, `ATP_REG_CBUF0) == g))
        begin
          cbuf[g] <= i_wdata;
        end
      end
    end
  endgenerate

  // sticky event flags, write one to clear, a new event wins
  always @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      evt_flags <= {`ATP_EVT_W{1'b0}};
    end
    else
    begin
      evt_flags <= (evt_flags &
                    ~((i_wr && i_addr == `ATP_REG_EVT) ? i_wdata[`ATP_EVT_W-1:0]
                                                       : {`ATP_EVT_W{1'b0}})) |
                   {mhit, top_ev, under_ev};
    end
  end

  // read mux
  always @*
  begin
    next_rdata = `ATP_RD_ZERO;
    if (chan_hit(i_addr, `ATP_REG_CBUF0))
    begin
      next_rdata = cbuf[chan_idx(i_addr, `ATP_REG_CBUF0)];
    end
    else if (chan_hit(i_addr, `ATP_REG_CCMP0))
    begin
      next_rdata = ccmp_flat[chan_idx(i_addr, `ATP_REG_CCMP0)*CW +: CW];
    end
    else
    begin
      case (i_addr)
        `ATP_REG_CTRL: next_rdata = timer_control_reg;
        `ATP_REG_PBUF: next_rdata = period_buffer;
        `ATP_REG_DTRR: next_rdata = {{(CW-DW){1'b0}}, deadtime_reload};
        `ATP_REG_PCMP: next_rdata = period_compare;
        `ATP_REG_CNT: next_rdata = updown_counter;
        `ATP_REG_STAT: next_rdata = {{(CW-2*`ATP_NPH-2){1'b0}}, dead, ff, count_down, run};
        `ATP_REG_EVT: next_rdata = {{(CW-`ATP_EVT_W){1'b0}}, evt_flags};
        default: next_rdata = `ATP_RD_ZERO;
      endcase
    end
  end

  always @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_rdata <= `ATP_RD_ZERO;
    end
    else
    begin
      o_rdata <= i_rd ? next_rdata : `ATP_RD_ZERO;
    end
  end
endmodule // atp_pwm

//--- sim/atp_gate_model.sv
// gate driver model: resolved pin levels and high-time counters
module atp_gate_model (
  input wire logic i_clock,
  input wire logic i_clr,
  input wire logic [5:0] i_out,
  input wire logic [5:0] i_oe,
  output logic [5:0] o_pin,
  output int o_hi [6]
);
  timeunit 1ns;
  timeprecision 1ns;
  // pull-down holds an undriven gate off
  assign o_pin = i_out & i_oe;
  always @(posedge i_clock)
    for (int k = 0; k < 6; k++)
      o_hi[k] <= i_clr ? 0 : o_hi[k] + int'(o_pin[k]);
endmodule // atp_gate_model

//--- sim/atp_pwm_sva.sv
// port checker for the asymmetric pwm unit
module atp_pwm_sva #(
  parameter CW = 16,
  parameter DW = 12
) (
  input wire i_clock,
  input wire i_nrst,
  input wire [4:0] i_addr,
  input wire [CW-1:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [CW-1:0] o_rdata,
  input wire [5:0] o_phase_out,
  input wire [5:0] o_phase_oe,
  input wire o_underflow_irq,
  input wire o_period_match_irq,
  input wire [2:0] o_duty_match_irq,
  input wire [1:0] o_aux_match_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [CW-1:0] ctrl;
  logic [2:0] quiet;
  logic last_top;
  wire [5:0] act = o_phase_out ^ {6{~ctrl[6]}};
  wire ctl_wr = i_wr && i_addr == 5'h00;
  wire any_irq = o_underflow_irq || o_period_match_irq || (|o_duty_match_irq);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);
  // shadow of the control word and cycles since its last write
  always @(posedge i_clock or negedge i_nrst)
    if (!i_nrst)
      ctrl <= 16'h000c;
    else if (ctl_wr)
      ctrl <= i_wdata;
  always @(posedge i_clock or negedge i_nrst)
    if (!i_nrst)
      quiet <= 3'h0;
    else if (ctl_wr)
      quiet <= 3'h0;
    else if (quiet != 3'h7)
      quiet <= quiet + 3'h1;
  // last counter turn seen
  always @(posedge i_clock or negedge i_nrst)
    if (!i_nrst)
      last_top <= 1'b0;
    else if (o_period_match_irq)
      last_top <= 1'b1;
    else if (o_underflow_irq || (ctl_wr && i_wdata[0] && !ctrl[0]))
      last_top <= 1'b0;
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == '0)
    else $error("read data outside read cycle");
  a_oe_mode: assert property (
    quiet == 3'h7 |-> o_phase_oe == {6{ctrl[5:4] == 2'b01}})
    else $error("output enable does not follow mode");
  a_stop_level: assert property (
    quiet == 3'h7 && ctrl[5:4] == 2'b01 && !ctrl[0]
    |-> o_phase_out == (ctrl[6] ? 6'h2a : 6'h15))
    else $error("stopped pin levels wrong");
  a_pair_overlap: assert property (
    o_phase_oe[0] && quiet != 3'h0 |-> (act & (act >> 1) & 6'h15) == 6'h00)
    else $error("both outputs of a pair active");
  a_irq_excl: assert property (!(o_underflow_irq && o_period_match_irq))
    else $error("underflow and period match together");
  a_under_alt: assert property (o_underflow_irq |-> last_top)
    else $error("underflow without preceding period match");
  a_top_alt: assert property (o_period_match_irq |-> !last_top)
    else $error("two period matches without underflow");
  a_irq_run: assert property (
    any_irq |-> ctrl[0] || $past(ctrl[0]) || $past(ctrl[0], 2))
    else $error("counter event while stopped");
endmodule // atp_pwm_sva

bind atp_pwm atp_pwm_sva #(
  .CW(CW),
  .DW(DW)
) u_sva (
  .i_clock(i_clock),
  .i_nrst(i_nrst),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .o_phase_out(o_phase_out),
  .o_phase_oe(o_phase_oe),
  .o_underflow_irq(o_underflow_irq),
  .o_period_match_irq(o_period_match_irq),
  .o_duty_match_irq(o_duty_match_irq),
  .o_aux_match_irq(o_aux_match_irq)
);

//--- sim/atp_pwm_tb_top.sv
// self-checking bench for the asymmetric pwm unit
module atp_pwm_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0;
  logic nrst = 0;
  logic [4:0] addr = 0;
  logic [15:0] wdata = 0;
  logic wr = 0;
  logic rd = 0;
  logic clr = 0;
  wire [15:0] rdata;
  wire [5:0] pout;
  wire [5:0] poe;
  wire [5:0] pin;
  wire und;
  wire top;
  wire [2:0] dmi;
  wire [1:0] ami;
  int hi [6];
  int cnt [5];
  int err_count = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  atp_pwm dut (
    .i_clock(clk),
    .i_nrst(nrst),
    .i_addr(addr),
    .i_wdata(wdata),
    .i_wr(wr),
    .i_rd(rd),
    .o_rdata(rdata),
    .o_phase_out(pout),
    .o_phase_oe(poe),
    .o_underflow_irq(und),
    .o_period_match_irq(top),
    .o_duty_match_irq(dmi),
    .o_aux_match_irq(ami)
  );
  atp_gate_model u_gate (
    .i_clock(clk),
    .i_clr(clr),
    .i_out(pout),
    .i_oe(poe),
    .o_pin(pin),
    .o_hi(hi)
  );
  task results;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wreg(input logic [4:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
    @(posedge clk);
  endtask
  task rreg(input logic [4:0] a, input logic [15:0] e);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdata, e);
    @(posedge clk);
  endtask
  task wt(input bit t);
    int i;
    for (i = 0; i < 100; i++)
    begin
      @(negedge clk);
      if ((t ? top : und) === 1'b1)
        break;
    end
    if (i == 100)
    begin
      chk(16'h0000, 16'h0001);
      results;
    end
    else
      @(posedge clk);
  endtask
  // settle, then count pin highs and events over four cycles
  task win;
    repeat (48) @(posedge clk);
    clr <= 1;
    @(posedge clk);
    clr <= 0;
    cnt = '{0, 0, 0, 0, 0};
    repeat (64)
    begin
      @(negedge clk);
      cnt[0] += int'(und);
      cnt[1] += int'(top);
      cnt[2] += int'(dmi[1]);
      cnt[3] += int'(ami[0]);
      cnt[4] += int'(ami[1]);
    end
    @(posedge clk);
    #1;
  endtask
  task s_reset;
    chk({10'h000, poe}, 16'h0000);
    rreg(5'h00, 16'h000c);
    rreg(5'h1f, 16'h0000);
  endtask
  task s_stopped;
    wreg(5'h07, 16'h0001);
    wreg(5'h01, 16'h0008);
    wreg(5'h02, 16'h0002);
    wreg(5'h03, 16'h0008);
    wreg(5'h04, 16'h0000);
    wreg(5'h05, 16'h0009);
    wreg(5'h06, 16'h0000);
    wreg(5'h00, 16'h001c);
    rreg(5'h0b, 16'h0002);
    chk({10'h000, poe}, 16'h003f);
    chk({10'h000, pout}, 16'h0015);
  endtask
  task s_run;
    wreg(5'h00, 16'h005d);
    win;
    chk(hi[0], 40);
    chk(hi[1], 8);
    chk(hi[2], 0);
    chk(hi[3], 64);
    chk(hi[4], 64);
    chk(hi[5], 0);
    chk(cnt[0], 4);
    chk(cnt[1], 4);
    chk(cnt[2], 4);
    chk(cnt[3], 0);
    chk(cnt[4], 4);
  endtask
  task s_dead_off;
    wreg(5'h00, 16'h005f);
    win;
    chk(hi[0], 48);
    chk(hi[1], 16);
  endtask
  task s_polarity;
    wreg(5'h00, 16'h001f);
    win;
    chk(hi[0], 16);
    chk(hi[1], 48);
    chk(hi[3], 0);
  endtask
  task s_transfer;
    wreg(5'h00, 16'h005d);
    wt(0);
    wreg(5'h01, 16'h000a);
    wreg(5'h02, 16'h0005);
    rreg(5'h0b, 16'h0002);
    wt(1);
    rreg(5'h08, 16'h0008);
    rreg(5'h0b, 16'h0005);
    wt(0);
    rreg(5'h08, 16'h000a);
    wreg(5'h00, 16'h0059);
    wreg(5'h02, 16'h0003);
    wt(1);
    wt(0);
    rreg(5'h0b, 16'h0005);
  endtask
  // stop, restart with a count tick every second clock
  task s_prescale;
    time t0;
    wreg(5'h00, 16'h0058);
    wreg(5'h00, 16'h015d);
    rreg(5'h09, 16'h0000);
    rreg(5'h09, 16'h0000);
    rreg(5'h09, 16'h0001);
    wt(1);
    t0 = $time;
    wt(0);
    chk(16'(($time - t0) / 10), 16'h0014);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    s_reset;
    s_stopped;
    s_run;
    s_dead_off;
    s_polarity;
    s_transfer;
    s_prescale;
    results;
  end
endmodule // atp_pwm_tb_top
